// [pkg/ckctl_pkg.sv]
// Package: constants, types and carriers of the clock control block
`default_nettype none

package ckctl_pkg;

  // Clock rates in MHz
  localparam int unsigned CKCTL_CLK_MHZ = 50;
  localparam int unsigned CKCTL_ROOT_MHZ = 16;

  // Register byte offsets on the bus
  localparam logic [11:0] CKCTL_OFS_DIV_CFG = 12'h408;
  localparam logic [11:0] CKCTL_OFS_GATE = 12'h410;
  localparam logic [11:0] CKCTL_OFS_SRC_SEL = 12'h414;
  localparam logic [11:0] CKCTL_OFS_STATUS = 12'h418;
  localparam logic [11:0] CKCTL_OFS_LP_DIS = 12'hA70;

  // Reset values
  localparam logic [15:0] CKCTL_RST_DIV_CFG = 16'h0441;
  localparam logic [15:0] CKCTL_RST_GATE = 16'h01C0;
  localparam logic [15:0] CKCTL_RST_SRC_SEL = 16'h0000;
  localparam logic [15:0] CKCTL_RST_LP_DIS = 16'h0004;

  // Writable bits; the rest read as zero
  localparam logic [15:0] CKCTL_MSK_DIV_CFG = 16'hFFFF;
  localparam logic [15:0] CKCTL_MSK_GATE = 16'h03FF;
  localparam logic [15:0] CKCTL_MSK_SRC_SEL = 16'h000F;
  localparam logic [15:0] CKCTL_MSK_LP_DIS = 16'h0007;

  // Field positions and widths
  localparam int unsigned CKCTL_SYS_DIV_LSB = 0;
  localparam int unsigned CKCTL_SYS_DIV_W = 6;
  localparam int unsigned CKCTL_CONV_DIV_LSB = 6;
  localparam int unsigned CKCTL_CONV_DIV_W = 4;
  localparam int unsigned CKCTL_SYS_SRC_LSB = 0;
  localparam int unsigned CKCTL_CONV_SRC_LSB = 2;
  localparam int unsigned CKCTL_CHOP_OFF_BIT = 2;
  localparam int unsigned CKCTL_SLEEP_OFF_BIT = 1;
  localparam int unsigned CKCTL_FE_OFF_BIT = 5;

  // Divisor limits
  localparam logic [5:0] CKCTL_SYS_DIV_MAX = 6'h20;
  localparam logic [5:0] CKCTL_DIV_ONE = 6'h01;
  localparam logic [3:0] CKCTL_CONV_DIV_TWO = 4'h2;

  // Source encodings, also the index of the source pin
  typedef enum logic [1:0] {
    CKCTL_SRC_FAST_INT = 2'b00,
    CKCTL_SRC_CRYSTAL = 2'b01,
    CKCTL_SRC_SLOW_INT = 2'b10,
    CKCTL_SRC_EXTERNAL = 2'b11
  } ckctl_src_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ckctl_avs_req_t;

endpackage : ckctl_pkg

`default_nettype wire

// [testbench/ckctl_props.sv]
// Checker: bus handshake and clock output properties of the clock control block
`default_nettype none

module ckctl_props (
  input wire logic I_CLK, // Clock
  input wire logic I_SYS_RST, // Reset
  input wire ckctl_pkg::ckctl_avs_req_t I_AVS_REQ, // Bus request
  input wire logic O_AVS_WAITREQUEST, // Wait
  input wire logic [31:0] O_AVS_READDATA, // Read data
  input wire logic O_SYS_CLK, // System clock
  input wire logic O_CONV_CLK, // Converter clock
  input wire logic O_CHOP_CLK, // Chop clock
  input wire logic O_FRONTEND_CTRL_CLK // Front-end clock
);
  timeunit 1ns;
  timeprecision 1ps;
  import ckctl_pkg::*;

  // One clock domain for all properties
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  wire logic req = I_AVS_REQ.read | I_AVS_REQ.write;

  // A phase lasts at least two samples
  sequence s_two(logic x);
    x [*2];
  endsequence

  AST_WAIT_ANSWER: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  AST_WAIT_ONE: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("wait low longer than one cycle");
  AST_WAIT_CAUSE: assert property ($fell(O_AVS_WAITREQUEST) |-> $past(req))
    else $error("answer without request");
  AST_RD_UPPER: assert property (!O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_CHOP_RST: assert property ($fell(I_SYS_RST) |-> !O_CHOP_CLK [*8])
    else $error("chop clock runs after reset");
  AST_FE_FOLLOW: assert property ($rose(O_FRONTEND_CTRL_CLK) |-> $past(O_SYS_CLK))
    else $error("front-end clock not from system clock");
  AST_SYS_HI: assert property ($rose(O_SYS_CLK) |-> s_two(O_SYS_CLK))
    else $error("short high on system clock");
  AST_SYS_LO: assert property ($fell(O_SYS_CLK) |-> s_two(!O_SYS_CLK))
    else $error("short low on system clock");
  AST_CONV_HI: assert property ($rose(O_CONV_CLK) |-> s_two(O_CONV_CLK))
    else $error("short high on converter clock");

endmodule : ckctl_props

bind ckctl_top ckctl_props u_props (
  .I_CLK(I_CLK),
  .I_SYS_RST(I_SYS_RST),
  .I_AVS_REQ(I_AVS_REQ),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_AVS_READDATA(O_AVS_READDATA),
  .O_SYS_CLK(O_SYS_CLK),
  .O_CONV_CLK(O_CONV_CLK),
  .O_CHOP_CLK(O_CHOP_CLK),
  .O_FRONTEND_CTRL_CLK(O_FRONTEND_CTRL_CLK)
);

`default_nettype wire

// [testbench/testbench.sv]
// Testbench: register access and clock output checks of the clock control block
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ckctl_pkg::*;

  localparam int HP[4] = '{5, 6, 8, 7};
  localparam logic [15:0] DV[5] = '{16'h0440, 16'h0482, 16'h04E0, 16'h0468, 16'h0401};
  localparam int PS[5] = '{10, 20, 320, 320, 10};
  localparam int PC[5] = '{10, 20, 10, 10, 10};

  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  ckctl_avs_req_t req = '0;
  logic [3:0] osc = 4'h0;
  wire wr;
  wire [31:0] rd;
  wire [4:0] ck;
  int unsigned cnt = 0;
  int fails = 0;
  int n_checks = 0;
  logic [3:0] be = 4'h3;

  ckctl_top u_dut (
    .I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST),
    .I_AVS_REQ(req),
    .I_OSC_PINS(osc),
    .O_AVS_WAITREQUEST(wr),
    .O_AVS_READDATA(rd),
    .O_SYS_CLK(ck[0]),
    .O_CONV_CLK(ck[1]),
    .O_CHOP_CLK(ck[2]),
    .O_SLEEP_TIMER_CLK(ck[3]),
    .O_FRONTEND_CTRL_CLK(ck[4])
  );

  // Clock of 20 ns
  initial begin
    forever #10 I_CLK = ~I_CLK;
  end

  // Slow source clocks, periods of 10, 12, 16 and 14 cycles
  always @(posedge I_CLK) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 4; i++) osc[i] <= 1'((cnt / HP[i]) % 2);
  end

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // One bus access; holds the request until wait is seen low
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.byteenable <= be;
    req.writedata <= {16'h0000, d};
    @(posedge I_CLK);
    while (wr !== 1'b0) @(posedge I_CLK);
    q = rd[15:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge I_CLK);
  endtask : acc

  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(1'b1, a, d, q);
  endtask : wreg

  task automatic rchk(input string s, input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    acc(1'b0, a, 16'h0000, q);
    chk(s, e, q);
  endtask : rchk

  // Period between second and third rise of a clock output; 0 when stopped
  task automatic per(input string s, input int i, input int e);
    int t;
    int r;
    int a;
    logic p;
    t = 0;
    r = 0;
    a = 0;
    p = 1'b1;
    while (r < 3 && t < 1500) begin
      @(posedge I_CLK);
      t++;
      if (ck[i] === 1'b1 && p === 1'b0) r++;
      if (ck[i] === 1'b1 && p === 1'b0 && r == 2) a = t;
      p = ck[i];
    end
    chk(s, 16'((r == 3) ? t - a : 0), 16'(e));
  endtask : per

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog
  initial begin
    #(60000 * 20);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [15:0] q;
    repeat (10) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_CLK);
    rchk("div_cfg", CKCTL_OFS_DIV_CFG, 16'h0441);
    rchk("src_sel", CKCTL_OFS_SRC_SEL, 16'h0000);
    rchk("lp_dis", CKCTL_OFS_LP_DIS, 16'h0004);
    rchk("gate", CKCTL_OFS_GATE, 16'h01C0);
    rchk("unmapped", 12'h400, 16'h0000);
    // Status after reset: fast internal source, both divisors one
    acc(1'b0, CKCTL_OFS_STATUS, 16'h0000, q);
    chk("status", 16'h0410, q & 16'h0FFF);
    // Start-up write of the two gate bits that want a one, bit 9 left clear
    wreg(CKCTL_OFS_GATE, 16'h01C9);
    per("sys_clk", 0, 10);
    per("conv_clk", 1, 10);
    per("chop_clk", 2, 0);
    per("sleep_clk", 3, 16);
    per("fe_clk", 4, 10);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      wreg(CKCTL_OFS_DIV_CFG, DV[k]);
      rchk("div_cfg", CKCTL_OFS_DIV_CFG, DV[k]);
      per("sys_clk", 0, PS[k]);
      per("conv_clk", 1, PC[k]);
    end
    wreg(CKCTL_OFS_DIV_CFG, 16'h0441);
    $display("test divisors done");
    for (int s = 0; s < 4; s++) begin
      wreg(CKCTL_OFS_SRC_SEL, 16'(((3 - s) << 2) | s));
      rchk("src_sel", CKCTL_OFS_SRC_SEL, 16'(((3 - s) << 2) | s));
      per("sys_clk", 0, 2 * HP[s]);
      per("conv_clk", 1, 2 * HP[3 - s]);
    end
    wreg(CKCTL_OFS_SRC_SEL, 16'h0000);
    $display("test sources done");
    wreg(CKCTL_OFS_LP_DIS, 16'h000A);
    rchk("lp_dis", CKCTL_OFS_LP_DIS, 16'h0002);
    per("chop_clk", 2, 16);
    per("sleep_clk", 3, 0);
    // Low lane only: the upper byte must keep its bit 8
    be = 4'h1;
    wreg(CKCTL_OFS_GATE, 16'h00E9);
    be = 4'h3;
    rchk("gate", CKCTL_OFS_GATE, 16'h01E9);
    wreg(CKCTL_OFS_GATE, 16'hFDE9);
    rchk("gate", CKCTL_OFS_GATE, 16'h01E9);
    per("fe_clk", 4, 0);
    per("sys_clk", 0, 10);
    $display("test gates done");
    end_of_test();
  end

endmodule : testbench

`default_nettype wire

// [verilog/ckctl_clkgen.sv]
// Glitch-free source mux and divider for one generated clock
`default_nettype none

module ckctl_clkgen #(
  parameter int unsigned DIV_W = 6
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic [3:0] i_edge, // Edge pulses of each source
  input wire ckctl_pkg::ckctl_src_t i_sel, // Requested source
  input wire logic [DIV_W-1:0] i_div, // Requested divisor, 1 or more
  output logic o_clk, // Generated clock
  output ckctl_pkg::ckctl_src_t o_sel, // Source in use
  output logic [DIV_W-1:0] o_div // Divisor in use
);
  import ckctl_pkg::*;

  typedef enum logic [0:0] {
    CKCTL_PH_LOW = 1'b0,
    CKCTL_PH_HIGH = 1'b1
  } ckctl_phase_t;

  typedef struct packed {
    ckctl_phase_t phase;
    logic [DIV_W-1:0] cnt;
    ckctl_src_t sel;
    logic [DIV_W-1:0] div;
  } ckctl_gen_state_t;

  ckctl_gen_state_t st;
  ckctl_gen_state_t next_st;
  logic last_edge;

  // Each half period lasts div source half periods
  assign last_edge = (st.cnt + DIV_W'(1)) == st.div;

  // Count edges of the source in use; switch only at the end of a low phase
  always_comb begin
    next_st = st;
    if (i_edge[st.sel]) begin
      if (!last_edge) begin
        next_st.cnt = st.cnt + DIV_W'(1);
      end else begin
        next_st.cnt = '0;
        case (st.phase)
          CKCTL_PH_HIGH: begin
            next_st.phase = CKCTL_PH_LOW;
          end
          CKCTL_PH_LOW: begin
            if (i_sel != st.sel || i_div != st.div) begin
              next_st.sel = i_sel; // RL19
              next_st.div = i_div; // RL19
            end else begin
              next_st.phase = CKCTL_PH_HIGH;
            end
          end
          default: begin
            next_st.phase = CKCTL_PH_LOW;
          end
        endcase
      end
    end
  end

  // State register, reset to the fast internal oscillator undivided
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{CKCTL_PH_LOW, '0, CKCTL_SRC_FAST_INT, DIV_W'(1)}; // RL17
    end else begin
      st <= next_st;
    end
  end

  assign o_clk = (st.phase == CKCTL_PH_HIGH);
  assign o_sel = st.sel;
  assign o_div = st.div;

endmodule : ckctl_clkgen

`default_nettype wire

// [verilog/ckctl_top.sv]
// Clock control: source select, dividers, clock gates and register slave
//
// The Avalon-MM register port is this design's own decision.
`default_nettype none

// What this block does
// [RL1] Converter clock divides root by field [9:6]; the code divides by two only for value 2 and by one for any other value
// [RL2] System clock divides root by field [5:0]
// [RL3] System divisor above 32 divides by 32
// [RL4] System divisor zero behaves as one
// [RL5] Software keeps system clock at most 16 MHz
// [RL6] Converter source chosen by field [3:2]
// [RL7] System source chosen by field [1:0]
// [RL8] Software avoids slow oscillator as source
// [RL9] Chop clock stops while bit 2 set
// [RL10] Sleep timer clock stops while bit 1 set
// [RL11] Front-end control clock off while bit 5
// [RL12] Software sets two gate bits at start
// [RL13] Software leaves divider bits [15:10] alone
// [RL14] Software never writes gate bit 9
// [RL15] Divider configuration resets to 0x0441
// [RL16] Source select resets to zero
// [RL17] Power-up runs from fast internal oscillator
// [RL18] Software divides 32 MHz sources by two
// [RL19] Switching and gating never truncate pulses
module ckctl_top (
  input wire logic I_CLK, // 50 MHz system clock
  input wire logic I_SYS_RST, // Synchronous reset, high
  input wire ckctl_pkg::ckctl_avs_req_t I_AVS_REQ, // Avalon-MM request
  input wire logic [3:0] I_OSC_PINS, // Source clocks, by encoding
  output logic O_AVS_WAITREQUEST, // Avalon-MM wait
  output logic [31:0] O_AVS_READDATA, // Avalon-MM read data
  output logic O_SYS_CLK, // Divided system clock
  output logic O_CONV_CLK, // Divided converter clock
  output logic O_CHOP_CLK, // Gated chop clock
  output logic O_SLEEP_TIMER_CLK, // Gated sleep timer clock
  output logic O_FRONTEND_CTRL_CLK // Gated front-end control clock
);
  import ckctl_pkg::*;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] lvl;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] div_cfg;
    logic [15:0] gate;
    logic [15:0] src_sel;
    logic [15:0] lp_dis;
    logic chop_en;
    logic sleep_en;
    logic fe_en;
    logic chop;
    logic sleep;
    logic fe;
  } ckctl_top_state_t;

  ckctl_top_state_t st;
  ckctl_top_state_t next_st;

  logic [3:0] lvl_new;
  logic [3:0] src_edge;
  logic [5:0] sys_raw;
  logic [5:0] sys_eff;
  logic [3:0] conv_raw;
  logic [5:0] conv_eff;
  logic [1:0] conv_div_act;
  logic sys_clk;
  logic conv_clk;
  ckctl_src_t sys_src_act;
  ckctl_src_t conv_src_act;
  logic [5:0] sys_div_act;
  logic [5:0] conv_div_full;
  logic req;
  logic take;
  logic [15:0] rd_mux;
  logic [15:0] status;
  logic [15:0] lane;

  // Merge a bus write into a 16-bit register by byte lane
  function automatic logic [15:0] apply_write(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] bm,
    input logic [15:0] msk
  );
    apply_write = ((old & ~bm) | (wd & bm)) & msk;
  endfunction : apply_write

  // Per-source level filter: a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_src
      assign lvl_new[g] = (st.sync2[g] == st.sync3[g]) ? st.sync3[g] : st.lvl[g];
      assign src_edge[g] = lvl_new[g] != st.lvl[g];
    end
  endgenerate

  // Effective system divisor: zero acts as one, large values saturate
  always_comb begin
    sys_raw = st.div_cfg[CKCTL_SYS_DIV_LSB +: CKCTL_SYS_DIV_W]; // RL2
    if (sys_raw == '0) begin
      sys_eff = CKCTL_DIV_ONE; // RL4
    end else if (sys_raw > CKCTL_SYS_DIV_MAX) begin
      sys_eff = CKCTL_SYS_DIV_MAX; // RL3
    end else begin
      sys_eff = sys_raw; // RL2
    end
  end

  // Effective converter divisor: only one and two exist
  always_comb begin
    conv_raw = st.div_cfg[CKCTL_CONV_DIV_LSB +: CKCTL_CONV_DIV_W]; // RL1
    if (conv_raw == CKCTL_CONV_DIV_TWO) begin
      conv_eff = 6'h02; // RL1
    end else begin
      conv_eff = CKCTL_DIV_ONE; // RL1
    end
  end

  // System clock generator
  ckctl_clkgen #(
    .DIV_W(6)
  ) u_sys_gen (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_edge(src_edge),
    .i_sel(ckctl_src_t'(st.src_sel[CKCTL_SYS_SRC_LSB +: 2])), // RL7
    .i_div(sys_eff),
    .o_clk(sys_clk),
    .o_sel(sys_src_act),
    .o_div(sys_div_act)
  );

  // Converter clock generator
  ckctl_clkgen #(
    .DIV_W(6)
  ) u_conv_gen (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_edge(src_edge),
    .i_sel(ckctl_src_t'(st.src_sel[CKCTL_CONV_SRC_LSB +: 2])), // RL6
    .i_div(conv_eff),
    .o_clk(conv_clk),
    .o_sel(conv_src_act),
    .o_div(conv_div_full)
  );

  assign conv_div_act = conv_div_full[1:0];

  // Status: sources and divisors in use, filtered source levels
  assign status = {st.lvl, conv_div_act, sys_div_act, conv_src_act, sys_src_act};

  // Bus handshake terms
  assign req = I_AVS_REQ.read | I_AVS_REQ.write;
  assign take = I_AVS_REQ.write && !st.wreq;
  assign lane = {{8{I_AVS_REQ.byteenable[1]}}, {8{I_AVS_REQ.byteenable[0]}}};

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    case (I_AVS_REQ.address)
      CKCTL_OFS_DIV_CFG: rd_mux = st.div_cfg;
      CKCTL_OFS_GATE: rd_mux = st.gate;
      CKCTL_OFS_SRC_SEL: rd_mux = st.src_sel;
      CKCTL_OFS_LP_DIS: rd_mux = st.lp_dis;
      CKCTL_OFS_STATUS: rd_mux = status;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    // Source synchronisers
    next_st.sync1 = I_OSC_PINS;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    next_st.lvl = lvl_new;
    // One wait cycle, then one answer cycle
    next_st.wreq = !(req && st.wreq);
    if (I_AVS_REQ.read && st.wreq) begin
      next_st.rdata = {16'h0000, rd_mux};
    end
    // Writes land at the edge where waitrequest is seen low
    if (take) begin
      case (I_AVS_REQ.address)
        CKCTL_OFS_DIV_CFG: begin
          next_st.div_cfg = apply_write(st.div_cfg, I_AVS_REQ.writedata[15:0],
                                        lane, CKCTL_MSK_DIV_CFG);
        end
        CKCTL_OFS_GATE: begin
          next_st.gate = apply_write(st.gate, I_AVS_REQ.writedata[15:0],
                                     lane, CKCTL_MSK_GATE);
        end
        CKCTL_OFS_SRC_SEL: begin
          next_st.src_sel = apply_write(st.src_sel, I_AVS_REQ.writedata[15:0],
                                        lane, CKCTL_MSK_SRC_SEL);
        end
        CKCTL_OFS_LP_DIS: begin
          next_st.lp_dis = apply_write(st.lp_dis, I_AVS_REQ.writedata[15:0],
                                       lane, CKCTL_MSK_LP_DIS);
        end
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end
    // Gate enables move only while their source is low
    if (!st.lvl[CKCTL_SRC_SLOW_INT]) begin
      next_st.chop_en = !st.lp_dis[CKCTL_CHOP_OFF_BIT]; // RL9 RL19
      next_st.sleep_en = !st.lp_dis[CKCTL_SLEEP_OFF_BIT]; // RL10 RL19
    end
    if (!sys_clk) begin
      next_st.fe_en = !st.gate[CKCTL_FE_OFF_BIT]; // RL11 RL19
    end
    // Gated clocks, each from a flip-flop
    next_st.chop = st.lvl[CKCTL_SRC_SLOW_INT] & st.chop_en; // RL9
    next_st.sleep = st.lvl[CKCTL_SRC_SLOW_INT] & st.sleep_en; // RL10
    next_st.fe = sys_clk & st.fe_en; // RL11
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st <= '0;
      st.wreq <= 1'b1;
      st.div_cfg <= CKCTL_RST_DIV_CFG; // RL15
      st.gate <= CKCTL_RST_GATE;
      st.src_sel <= CKCTL_RST_SRC_SEL; // RL16 RL17
      st.lp_dis <= CKCTL_RST_LP_DIS; // RL9 RL10
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign O_AVS_WAITREQUEST = st.wreq;
  assign O_AVS_READDATA = st.rdata;
  assign O_SYS_CLK = sys_clk;
  assign O_CONV_CLK = conv_clk;
  assign O_CHOP_CLK = st.chop;
  assign O_SLEEP_TIMER_CLK = st.sleep;
  assign O_FRONTEND_CTRL_CLK = st.fe;

endmodule : ckctl_top

`default_nettype wire
